// File: common/lcdc_regs.vh
// Constants for the segment LCD driver serial command decoder.
// Assumes inclusion by bare name from the design file.
`ifndef LCDC_REGS_VH
`define LCDC_REGS_VH

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define LCDC_MODE_READ      3'h6
`define LCDC_MODE_WRITE     3'h5
`define LCDC_MODE_CMD       3'h4

// ----------------------------------------
// Frame lengths
// ----------------------------------------
`define LCDC_MODE_BITS      3
`define LCDC_ADDR_BITS      6
`define LCDC_DATA_BITS      4
`define LCDC_CMD_BITS       9

// ----------------------------------------
// Clock source codes and reset values
// ----------------------------------------
`define LCDC_CLK_SRC_XTAL   2'h1
`define LCDC_CLK_SRC_RC     2'h2
`define LCDC_CLK_SRC_EXT    2'h3
`define LCDC_RST_CLK_SRC    2'h2
`define LCDC_RST_RATE       3'h0
`define LCDC_RST_BIAS_THIRD 1'h0
`define LCDC_RST_COMMONS    2'h0

// ----------------------------------------
// Timing: the time base runs off one tick per 1/128 s
// ----------------------------------------
`define LCDC_TICK_HZ        128
`define LCDC_CLK_HZ         125000000
`define LCDC_TICK_CYCLES    (`LCDC_CLK_HZ / `LCDC_TICK_HZ)
`define LCDC_WDT_TIME_S     4

`endif

// File: rtl/lcdc_cmd_decoder.v
// Serial mode and command decoder of a 32x4 segment LCD driver, with display RAM,
// configuration state, time base, watchdog, tone and interrupt outputs.
// Assumes cs_n, wr_n, rd_n and data_in are synchronous to clk.
//
// Notes on behaviour
// - Read frame: 110, address MSB first, data LSB
// - Write frame: 101, address MSB first, data LSB
// - Mode 101 also allows read-modify-write access
// - Mode 100 gives nine-bit commands, don't-cares ignored
// - Further nine-bit groups decode as commands
// - System disable stops bias, and oscillator unless source is external
// - System enable starts oscillator only
// - Bias generator off and on commands
// - Time base output routing off and on
// - Watchdog flag routing off and on
// - Tone outputs off and on
// - Pattern 0000-11XX clears time base counter
// - Pattern 0000-111X clears watchdog stage
// - Clock source select: crystal, RC, external
// - Tone four or two kHz select
// - Time base rate 2^n Hz, watchdog 4s/2^n
// - Test mode entry and normal mode select
// - Power-on defaults: all off, RC, normal
// - Chip select high resets serial interface
// - Bits sampled on write strobe rising edge
// - Read bit driven at read strobe fall
// - Watchdog time-out holds interrupt low until cleared
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_regs.vh"

module lcdc_cmd_decoder #(
	parameter TICK_CYCLES = `LCDC_TICK_CYCLES,
	parameter RAM_WORDS   = 32
) (
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Serial interface
	input  wire       cs_n,
	input  wire       wr_n,
	input  wire       rd_n,
	input  wire       data_in,
	output reg        data_out,
	output reg        data_oe,
	// Configuration state
	output reg        osc_on_q,
	output reg        bias_gen_on_q,
	output reg [1:0]  clk_src_q,
	output reg        bias_third_q,
	output reg [1:0]  commons_q,
	output reg        test_mode_q,
	// Tone
	output reg        buzzer_out,
	output reg        buzzer_out_n,
	// Interrupt pin, open drain
	output reg        irq_out,
	output reg        irq_oe
);

	// ----------------------------------------
	// Serial front end
	// ----------------------------------------
	localparam ST_MODE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_CMD  = 2'h3;

	reg  [1:0]  state_q;
	reg  [2:0]  mode_q;
	reg  [3:0]  cnt_q;
	reg  [8:0]  shift_q;
	reg  [5:0]  addr_q;
	reg  [3:0]  wdata_q;
	reg         wr_n_q;
	reg         rd_n_q;
	reg  [3:0]  ram [0:RAM_WORDS-1];
	reg  [1:0]  rbit_q;

	wire        wr_rise = wr_n & ~wr_n_q;
	wire        rd_fall = ~rd_n & rd_n_q;
	wire [8:0]  cmd_word = {shift_q[7:0], data_in};
	wire        cmd_done = (state_q == ST_CMD) && wr_rise && (cnt_q == 4'h8) && !cs_n;
	wire [4:0]  ram_idx = addr_q[4:0];

	// Strobe history resets to the idle level so that no false edge follows reset.
	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
		end
		else
		begin
			wr_n_q <= wr_n;
			rd_n_q <= rd_n;
		end
	end

	always @(posedge clk)
	begin
		if (rst || cs_n)
		begin
			state_q      <= ST_MODE;
			mode_q       <= 3'h0;
			cnt_q        <= 4'h0;
			shift_q      <= 9'h000;
			addr_q       <= 6'h00;
			wdata_q      <= 4'h0;
			rbit_q       <= 2'h0;
			data_oe      <= 1'b0;
			// The last read bit holds while deselected; only the line enable drops.
			if (rst)
				data_out <= 1'b0;
		end
		else
		begin
			if (wr_rise)
			begin
				shift_q <= cmd_word;
				case (state_q)
					ST_MODE:
					begin
						if (cnt_q == 4'h2)
						begin
							cnt_q  <= 4'h0;
							mode_q <= cmd_word[2:0];
							if (cmd_word[2:0] == `LCDC_MODE_CMD)
								state_q <= ST_CMD;
							else if (cmd_word[2:0] == `LCDC_MODE_READ || cmd_word[2:0] == `LCDC_MODE_WRITE)
								state_q <= ST_ADDR;
							else
								state_q <= ST_MODE;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					ST_ADDR:
					begin
						// Address arrives most significant bit first.
						if (cnt_q == 4'h5)
						begin
							addr_q  <= cmd_word[5:0];
							cnt_q   <= 4'h0;
							state_q <= ST_DATA;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					ST_DATA:
					begin
						// Data arrives bit zero first; in write mode the fourth bit stores and moves to next address.
						wdata_q <= {data_in, wdata_q[3:1]};
						if (cnt_q == 4'h3 && mode_q == `LCDC_MODE_WRITE)
						begin
							ram[ram_idx] <= {data_in, wdata_q[3:1]};
							addr_q       <= addr_q + 6'h01;
							cnt_q        <= 4'h0;
							rbit_q       <= 2'h0;
						end
						else
							cnt_q <= cnt_q + 4'h1;
					end
					ST_CMD:
					begin
						// Each group of nine bits is one command, mode code sent once.
						if (cnt_q == 4'h8)
							cnt_q <= 4'h0;
						else
							cnt_q <= cnt_q + 4'h1;
					end
					default:
						state_q <= ST_MODE;
				endcase
			end
			if (rd_fall && state_q == ST_DATA)
			begin
				// Reads send bit zero first; after four bits in read mode the address advances.
				data_oe      <= 1'b1;
				data_out     <= ram[ram_idx][rbit_q];
				rbit_q       <= rbit_q + 2'h1;
				if (rbit_q == 2'h3 && mode_q == `LCDC_MODE_READ)
					addr_q <= addr_q + 6'h01;
			end
			if (wr_rise)
				data_oe <= 1'b0;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	reg         tb_route_q;
	reg         wdt_route_q;
	reg         tone_on_q;
	reg         tone_low_q;
	reg         irq_en_q;
	reg  [2:0]  rate_q;
	reg         tb_clr;
	reg         wdt_clr;

	always @*
	begin
		tb_clr  = cmd_done && cmd_word[8:5] == 4'h0 && cmd_word[4:3] == 2'h3;
		wdt_clr = cmd_done && cmd_word[8:5] == 4'h0 && cmd_word[4:2] == 3'h7;
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			osc_on_q      <= 1'b0;
			bias_gen_on_q <= 1'b0;
			clk_src_q     <= `LCDC_RST_CLK_SRC;
			bias_third_q  <= `LCDC_RST_BIAS_THIRD;
			commons_q     <= `LCDC_RST_COMMONS;
			test_mode_q   <= 1'b0;
			tb_route_q    <= 1'b0;
			wdt_route_q   <= 1'b0;
			tone_on_q     <= 1'b0;
			tone_low_q    <= 1'b0;
			irq_en_q      <= 1'b0;
			rate_q        <= `LCDC_RST_RATE;
		end
		else if (cmd_done)
		begin
			// Bit zero of the word is the trailing don't-care.
			case (cmd_word[8:6])
				3'h0:
				begin
					if (cmd_word[5] == 1'b0)
					begin
						case (cmd_word[4:1])
							4'h0:
							begin
								if (clk_src_q != `LCDC_CLK_SRC_EXT)
									osc_on_q <= 1'b0;
								bias_gen_on_q <= 1'b0;
							end
							4'h1: osc_on_q      <= 1'b1;
							4'h2: bias_gen_on_q <= 1'b0;
							4'h3: bias_gen_on_q <= 1'b1;
							4'h4: tb_route_q    <= 1'b0;
							4'h6: tb_route_q    <= 1'b1;
							4'h5: wdt_route_q   <= 1'b0;
							4'h7: wdt_route_q   <= 1'b1;
							4'h8: tone_on_q     <= 1'b0;
							4'h9: tone_on_q     <= 1'b1;
							default: ;
						endcase
					end
					else if (cmd_word[4:3] != 2'h0)
						clk_src_q <= cmd_word[4:3];
				end
				3'h1:
				begin
					if (cmd_word[5] == 1'b0 && cmd_word[4:3] != 2'h3)
					begin
						commons_q    <= cmd_word[4:3];
						bias_third_q <= cmd_word[1];
					end
				end
				3'h2: tone_low_q <= 1'b0;
				3'h3: tone_low_q <= 1'b1;
				3'h4: irq_en_q   <= cmd_word[4];
				3'h5: rate_q     <= cmd_word[3:1];
				3'h7:
				begin
					if (cmd_word[5:1] == 5'h00)
						test_mode_q <= 1'b1;
					else if (cmd_word[5:1] == 5'h03)
						test_mode_q <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Time base, watchdog, tone and interrupt
	// ----------------------------------------
	reg  [31:0] tick_cnt_q;
	reg  [6:0]  tb_cnt_q;
	reg  [11:0] wdt_cnt_q;
	reg         wdt_flag_q;
	reg  [6:0]  tb_cnt_d;
	wire        tick = (tick_cnt_q == TICK_CYCLES - 1);
	wire        running = osc_on_q;
	wire [11:0] wdt_limit = 12'h200 >> rate_q;
	wire        wdt_hit = tick && !wdt_flag_q && (wdt_cnt_q + 12'h001 >= wdt_limit);
	reg  [3:0]  tone_div_q;

	always @*
	begin
		tb_cnt_d = tb_cnt_q + 7'h01;
	end

	always @(posedge clk)
	begin
		if (rst || !running)
		begin
			tick_cnt_q <= 32'h0;
			tb_cnt_q   <= 7'h00;
			wdt_cnt_q  <= 12'h000;
			wdt_flag_q <= 1'b0;
			tone_div_q <= 4'h0;
		end
		else
		begin
			tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
			tone_div_q <= tone_div_q + 4'h1;
			if (tb_clr)
				tb_cnt_q <= 7'h00;
			else if (tick)
				tb_cnt_q <= tb_cnt_d;
			if (wdt_clr || !irq_en_q)
			begin
				// A time-out in the same cycle as a clear still sets the flag.
				wdt_cnt_q  <= 12'h000;
				wdt_flag_q <= wdt_hit && irq_en_q;
			end
			else if (tick && !wdt_flag_q)
			begin
				if (wdt_hit)
					wdt_flag_q <= 1'b1;
				wdt_cnt_q <= wdt_cnt_q + 12'h001;
			end
		end
	end

	// Time base square wave: bit (6-n) of the 128 Hz tick count gives 2^n Hz.
	// The 128 Hz rate has no counter bit and uses the second half of each tick period.
	reg         tb_wave;

	always @*
	begin
		if (rate_q == 3'h7)
			tb_wave = (tick_cnt_q >= TICK_CYCLES / 2);
		else
			tb_wave = tb_cnt_q[3'h6 - rate_q];
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			buzzer_out   <= 1'b0;
			buzzer_out_n <= 1'b0;
			irq_out      <= 1'b0;
			irq_oe       <= 1'b0;
		end
		else
		begin
			// Tone is a scaled stand-in; low pitch uses one more divide stage.
			if (tone_on_q && running)
			begin
				buzzer_out   <= tone_low_q ? tone_div_q[3] : tone_div_q[2];
				buzzer_out_n <= tone_low_q ? ~tone_div_q[3] : ~tone_div_q[2];
			end
			else
			begin
				buzzer_out   <= 1'b0;
				buzzer_out_n <= 1'b0;
			end
			irq_out <= 1'b0;
			irq_oe  <= irq_en_q && ((wdt_route_q && wdt_flag_q) || (tb_route_q && tb_wave));
		end
	end

endmodule // lcdc_cmd_decoder

`default_nettype wire

// File: test/lcdc_cmd_decoder_sva.sv
// Port assertions for the LCD command decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_sva (
	// Clock, reset and serial pins
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       cs_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       data_out,
	input wire logic       data_oe,
	// State and outputs
	input wire logic       osc_on_q,
	input wire logic       bias_gen_on_q,
	input wire logic [1:0] clk_src_q,
	input wire logic [1:0] commons_q,
	input wire logic       buzzer_out,
	input wire logic       buzzer_out_n,
	input wire logic       irq_out
);
	logic      wr_q, rd_q, rise_q, fall_q;
	wire [5:0] cfg = {osc_on_q, bias_gen_on_q, clk_src_q, commons_q};
	always @(posedge clk)
	begin
		wr_q   <= wr_n;
		rd_q   <= rd_n;
		rise_q <= wr_n & ~wr_q & ~cs_n & ~rst;
		fall_q <= rd_q & ~rd_n & ~cs_n & ~rst;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_cfg_wr;
		!$stable(cfg) |-> rise_q || $past(rise_q) || $past(rise_q, 2);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("config moved without a strobe");
	property p_cfg_cs;
		cs_n ##1 cs_n |-> $stable(cfg);
	endproperty
	a_cfg_cs: assert property (p_cfg_cs) else $error("config moved while deselected");
	property p_oe_cs;
		data_oe |-> !$past(cs_n);
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("line driven while deselected");
	property p_oe_rd;
		$rose(data_oe) |-> fall_q || $past(fall_q);
	endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("drive began without read strobe");
	property p_dout_rd;
		!$stable(data_out) |-> fall_q || $past(fall_q);
	endproperty
	a_dout_rd: assert property (p_dout_rd) else $error("read bit moved without strobe");
	property p_bz_diff;
		!(buzzer_out && buzzer_out_n);
	endproperty
	a_bz_diff: assert property (p_bz_diff) else $error("tone pair not differential");
	property p_bz_osc;
		!osc_on_q ##1 !osc_on_q |-> !buzzer_out && !buzzer_out_n;
	endproperty
	a_bz_osc: assert property (p_bz_osc) else $error("tone active with oscillator off");
	property p_irq_low;
		irq_out == 1'b0;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt pin driven high");
	property p_src_com;
		clk_src_q != 2'h0 && commons_q != 2'h3;
	endproperty
	a_src_com: assert property (p_src_com) else $error("illegal source or commons");
endmodule // lcdc_cmd_decoder_sva
bind lcdc_cmd_decoder lcdc_cmd_decoder_sva u_sva (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
	.rd_n(rd_n), .data_out(data_out), .data_oe(data_oe), .osc_on_q(osc_on_q), .bias_gen_on_q(bias_gen_on_q),
	.clk_src_q(clk_src_q), .commons_q(commons_q), .buzzer_out(buzzer_out), .buzzer_out_n(buzzer_out_n),
	.irq_out(irq_out));
`default_nettype wire

// File: test/lcdc_host_model.sv
// Behavioural host that drives the four-wire serial port.
// Assumes the device drives the data line while data_oe is high.
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
	// Clock
	input  wire logic clk,
	// Serial pins
	output var  logic cs_n,
	output var  logic wr_n,
	output var  logic rd_n,
	output wire logic line,
	input  wire logic data_out,
	input  wire logic data_oe
);
	logic drv = 1'b0, hd = 1'b1;
	// A released line not driven by the device shows the inverse of the last host bit, never a stale copy.
	assign line = hd ? drv : (data_oe ? data_out : ~drv);
	initial
	begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
	end
	task automatic sel;
		@(posedge clk) cs_n <= 1'b1;
		repeat (2) @(posedge clk);
		cs_n <= 1'b0;
	endtask
	task automatic send(input logic [8:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge clk);
			hd   <= 1'b1;
			drv  <= v[i];
			wr_n <= 1'b0;
			@(posedge clk);
			@(posedge clk) wr_n <= 1'b1;
			@(posedge clk);
		end
	endtask
	task automatic recv(output logic [3:0] d);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			hd   <= 1'b0;
			rd_n <= 1'b0;
			repeat (3) @(posedge clk);
			rd_n <= 1'b1;
			@(posedge clk) d[i] = line;
		end
	endtask
endmodule // lcdc_host_model
`default_nettype wire

// File: test/lcdc_cmd_decoder_bench.sv
// Self-checking bench for the LCD command decoder.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_regs.vh"
module lcdc_cmd_decoder_bench;
	logic       clk = 1'b0, rst = 1'b1;
	wire        cs_n, wr_n, rd_n, line, d_out, d_oe, osc, bias, third, test, bz, bz_n, irq, irq_oe;
	wire  [1:0] src, coms;
	int         err_count, checks_done, n;
	logic [3:0] d;
	logic [8:0] cv [14] = '{9'h003, 9'h006, 9'h005, 9'h006, 9'h001, 9'h03B, 9'h003,
		9'h001, 9'h028, 9'h030, 9'h056, 9'h05A, 9'h1C1, 9'h1C6};
	logic [7:0] ev [14] = '{8'hA0, 8'hE0, 8'hA0, 8'hE0, 8'h20, 8'h30, 8'hB0,
		8'hB0, 8'h90, 8'hA0, 8'hAC, 8'hAC, 8'hAD, 8'hAC};
	lcdc_cmd_decoder #(.TICK_CYCLES(4)) uut (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.data_in(line), .data_out(d_out), .data_oe(d_oe), .osc_on_q(osc), .bias_gen_on_q(bias),
		.clk_src_q(src), .bias_third_q(third), .commons_q(coms), .test_mode_q(test), .buzzer_out(bz),
		.buzzer_out_n(bz_n), .irq_out(irq), .irq_oe(irq_oe));
	lcdc_host_model u_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .line(line),
		.data_out(d_out), .data_oe(d_oe));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_hi(input logic use_bz);
		n = 0;
		while ((use_bz ? bz : irq_oe) !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 3000)
			begin
				err_count++;
				end_of_test;
			end
		end
	endtask
	task automatic cmd(input logic [8:0] c);
		u_host.send(c, 9);
		repeat (3) @(negedge clk);
	endtask
	task automatic frame(input logic [2:0] m);
		u_host.sel;
		u_host.send(m, 3);
		u_host.send(6'h02, 6);
	endtask
	task automatic t_cmds;
		u_host.sel;
		u_host.send(`LCDC_MODE_CMD, 3);
		for (int i = 0; i < 14; i++)
		begin
			cmd(cv[i]);
			check("config", {osc, bias, src, third, coms, test}, ev[i]);
		end
		cmd(9'h012);
		wait_hi(1'b1);
		check("tone_on", 8'(n < 64), 8'h01);
		cmd(9'h0FF);
		wait_hi(1'b1);
		n = 0;
		while (bz === 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (bz === 1'b0 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		check("tone_low", 8'(n), 8'h08);
		cmd(9'h011);
		check("tone_off", {bz, bz_n}, 8'h00);
	endtask
	task automatic t_irq;
		cmd(9'h140);
		cmd(9'h01C);
		cmd(9'h00E);
		cmd(9'h110);
		wait_hi(1'b0);
		check("wdt_time", 8'(n > 1900 && n < 2100), 8'h01);
		repeat (20) @(negedge clk);
		check("irq_hold", irq_oe, 8'h01);
		cmd(9'h01C);
		check("wdt_clear", irq_oe, 8'h00);
		wait_hi(1'b0);
		cmd(9'h100);
		check("irq_off", irq_oe, 8'h00);
		cmd(9'h00A);
		cmd(9'h00C);
		cmd(9'h14E);
		cmd(9'h110);
		wait_hi(1'b0);
		check("tb_route", 8'(n < 8), 8'h01);
		cmd(9'h008);
		check("tb_off", irq_oe, 8'h00);
	endtask
	task automatic t_cs;
		u_host.sel;
		u_host.send(`LCDC_MODE_CMD, 3);
		u_host.send(5'h00, 5);
		u_host.sel;
		u_host.send(`LCDC_MODE_CMD, 3);
		cmd(9'h006);
		check("resync", bias, 8'h01);
	endtask
	task automatic t_ram;
		frame(`LCDC_MODE_WRITE);
		u_host.send(4'hC, 4);
		u_host.send(4'h6, 4);
		frame(`LCDC_MODE_READ);
		u_host.recv(d);
		check("rd0", d, 8'h03);
		u_host.recv(d);
		check("rd1", d, 8'h06);
		frame(`LCDC_MODE_WRITE);
		u_host.recv(d);
		check("rmw_rd", d, 8'h03);
		u_host.send(4'h9, 4);
		frame(`LCDC_MODE_READ);
		u_host.recv(d);
		check("rmw_wr", d, 8'h09);
	endtask
	initial
	begin
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("reset", {osc, bias, src, third, coms, test}, 8'h20);
		check("reset_irq", irq_oe, 8'h00);
		check("reset_tone", {bz, bz_n}, 8'h00);
		t_cmds;
		t_irq;
		t_cs;
		t_ram;
		end_of_test;
	end
endmodule // lcdc_cmd_decoder_bench
`default_nettype wire
